// *** inc/kpi_pkg.sv ***
/*
 * Package for the keyboard pin interrupt block: register offsets, field
 * positions, reset values and packed carriers; all but the carriers and SYNC_STAGES are used by the design files.
 * Assumes a 32-bit APB master with word-aligned addresses.
 */
package kpi_pkg;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_PIN_ENABLE     = 8'h04;
    localparam logic [7:0] OFS_POLARITY       = 8'h08;
    localparam logic [7:0] OFS_PULL_ENABLE    = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STATUS     = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK       = 8'h14;

    // ==========================================================
    // Status/control field positions
    // ==========================================================
    localparam int BIT_MODE  = 0;
    localparam int BIT_IRQEN = 1;
    localparam int BIT_ACK   = 2;
    localparam int BIT_FLAG  = 3;

    // Interrupt status bit positions
    localparam int IRQ_EVENT = 0;
    localparam int IRQ_SET   = 1;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] RST_PIN_ENABLE = 8'h00;
    localparam logic [7:0] RST_POLARITY   = 8'h00;
    localparam logic [7:0] RST_PULL       = 8'h00;
    localparam logic [1:0] RST_IRQ_MASK   = 2'h0;

    // Number of synchroniser stages on each pin
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic [7:0] pin_enable_mask;
        logic [7:0] polarity_select;
        logic       detect_mode_bit;
    } kpi_cfg_t;

    typedef struct packed {
        logic [7:0] pull_enable;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
    } kpi_pull_t;

endpackage

// *** hw/kpi_sync.sv ***
/*
 * Two-stage synchroniser bank for asynchronous keyboard pins.
 * Assumes pins are asynchronous to clk_in; only the last stage is used.
 */
`timescale 1ns/100ps

module kpi_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Pins
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // ==========================================================
    // Next values
    // ==========================================================
    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Stage registers
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule // kpi_sync

// *** hw/kpi_keyboard_interrupt_unit.sv ***
/*
 * Keyboard pin interrupt unit: per-pin enable and polarity, edge or
 * edge-and-level detection, shared event flag with acknowledge, pull control
 * and an APB register slave with sticky interrupt status and mask.
 * Assumes pins are asynchronous to clk_in and the APB master is on clk_in.
 */
// Design decisions made here: the placing of the registers and the APB interface to the registers.
// What this block does
// - Up to eight pins, each individually enabled
// - Polarity bit picks falling/low or rising/high
// - One mode bit: edge or edge-and-level
// - Falling edge: sampled one then zero
// - Rising edge: sampled zero then one
// - New edge only after all pins deasserted
// - Edge mode: valid edge sets shared flag
// - Flag with enable requests processor interrupt
// - Edge mode: acknowledge write clears flag
// - Level mode: edge or asserted level sets flag
// - Level mode: ack clears only when deasserted
// - Pull enabled: pullup at polarity zero, else pulldown
// - Eight pins, independently enabled sources
// - Flag bit3, ack bit2, enable bit1, mode bit0
// - Mode zero edge only, one edge-and-level
// - Ack reads zero; flag ignores writes
`timescale 1ns/100ps

module kpi_keyboard_interrupt_unit #(
    parameter int PINS = 8
) (
    // Clock and reset
    input  wire logic            clk_in,
    input  wire logic            rst_in,
    // APB slave
    input  wire logic            psel_in,
    input  wire logic            penable_in,
    input  wire logic            pwrite_in,
    input  wire logic [7:0]      paddr_in,
    input  wire logic [31:0]     pwdata_in,
    input  wire logic [3:0]      pstrb_in,
    output logic      [31:0]     prdata_out,
    output logic                 pready_out,
    output logic                 pslverr_out,
    // Keyboard pins
    input  wire logic [PINS-1:0] key_pin_in,
    // Pull resistor control per pin
    output logic      [PINS-1:0] pull_up_out,
    output logic      [PINS-1:0] pull_down_out,
    // Interrupts
    output logic                 key_irq_out,
    output logic                 irq_out
);

    // ==========================================================
    // Elaboration check
    // ==========================================================
    if (PINS < 1 || PINS > 8)
    begin : g_bad_pins
        $error("PINS must be between 1 and 8");
    end

    // ==========================================================
    // Register state
    // ==========================================================
    logic [PINS-1:0] pin_enable_mask_q, pin_enable_mask_d;
    logic [PINS-1:0] polarity_select_q, polarity_select_d;
    logic [PINS-1:0] pull_enable_q,     pull_enable_d;
    logic            detect_mode_q,     detect_mode_d;
    logic            key_irq_enable_q,  key_irq_enable_d;
    logic            key_event_flag_q,  key_event_flag_d;
    logic            armed_q,           armed_d;
    logic [PINS-1:0] prev_q,            prev_d;
    logic [1:0]      irq_status_q,      irq_status_d;
    logic [1:0]      irq_mask_q,        irq_mask_d;
    logic [31:0]     prdata_q,          prdata_d;

    logic [PINS-1:0] pin_sync;
    logic [PINS-1:0] asserted_now;
    logic [PINS-1:0] asserted_prev;
    logic            any_edge;
    logic            any_level;
    logic            detect;
    logic            wr_en;
    logic            rd_en;
    logic            ack_wr;
    logic            addr_ok;
    logic            flag_rise;

    // Zero-extends a PINS-wide field into a bus word
    function automatic logic [31:0] ext_word(input logic [PINS-1:0] v);
        logic [31:0] w;
        w = '0;
        w[PINS-1:0] = v;
        return w;
    endfunction

    // Writable low byte taken under its byte strobe
    function automatic logic [PINS-1:0] take_low(input logic [PINS-1:0] old,
                                                 input logic [31:0] data,
                                                 input logic [3:0] strb);
        return strb[0] ? data[PINS-1:0] : old;
    endfunction

    // ==========================================================
    // Pin synchroniser
    // ==========================================================
    kpi_sync #(
        .WIDTH    (PINS)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in (key_pin_in),
        .sync_out (pin_sync)
    );

    // ==========================================================
    // Detection
    // ==========================================================
    // Asserted level per pin follows polarity; disabled pins never assert
    always_comb
    begin
        asserted_now  = (pin_sync ^ ~polarity_select_q) & pin_enable_mask_q;
        asserted_prev = (prev_q ^ ~polarity_select_q) & pin_enable_mask_q;
        // Deasserted one cycle, asserted the next
        any_edge      = armed_q && |(asserted_now & ~asserted_prev);
        any_level     = |asserted_now;
        detect        = detect_mode_q ? (any_edge || any_level) : any_edge;
    end

    // ==========================================================
    // APB decode
    // ==========================================================
    always_comb
    begin
        wr_en   = psel_in && penable_in && pwrite_in;
        rd_en   = psel_in && !penable_in && !pwrite_in;
        addr_ok = (paddr_in[1:0] == 2'h0) &&
                  (paddr_in == kpi_pkg::OFS_STATUS_CONTROL ||
                   paddr_in == kpi_pkg::OFS_PIN_ENABLE ||
                   paddr_in == kpi_pkg::OFS_POLARITY ||
                   paddr_in == kpi_pkg::OFS_PULL_ENABLE ||
                   paddr_in == kpi_pkg::OFS_IRQ_STATUS ||
                   paddr_in == kpi_pkg::OFS_IRQ_MASK);
        ack_wr  = wr_en && pstrb_in[0] && paddr_in == kpi_pkg::OFS_STATUS_CONTROL &&
                  pwdata_in[kpi_pkg::BIT_ACK];
    end

    // ==========================================================
    // Next register values
    // ==========================================================
    always_comb
    begin
        pin_enable_mask_d = pin_enable_mask_q;
        polarity_select_d = polarity_select_q;
        pull_enable_d     = pull_enable_q;
        detect_mode_d     = detect_mode_q;
        key_irq_enable_d  = key_irq_enable_q;
        irq_mask_d        = irq_mask_q;
        prdata_d          = prdata_q;

        if (wr_en && pstrb_in[0])
        begin
            unique case (paddr_in)
                kpi_pkg::OFS_STATUS_CONTROL:
                begin
                    // Flag bit ignores writes
                    detect_mode_d    = pwdata_in[kpi_pkg::BIT_MODE];
                    key_irq_enable_d = pwdata_in[kpi_pkg::BIT_IRQEN];
                end
                kpi_pkg::OFS_PIN_ENABLE:  pin_enable_mask_d = take_low(pin_enable_mask_q, pwdata_in, pstrb_in);
                kpi_pkg::OFS_POLARITY:    polarity_select_d = take_low(polarity_select_q, pwdata_in, pstrb_in);
                kpi_pkg::OFS_PULL_ENABLE: pull_enable_d     = take_low(pull_enable_q, pwdata_in, pstrb_in);
                kpi_pkg::OFS_IRQ_MASK:    irq_mask_d        = pwdata_in[1:0];
                default: ;
            endcase
        end

        // Read data captured in the setup cycle, shown in the access cycle
        if (rd_en)
        begin
            unique case (paddr_in)
                kpi_pkg::OFS_STATUS_CONTROL:
                begin
                    prdata_d = 32'h0000_0000;
                    prdata_d[kpi_pkg::BIT_FLAG]  = key_event_flag_q;
                    prdata_d[kpi_pkg::BIT_IRQEN] = key_irq_enable_q;
                    prdata_d[kpi_pkg::BIT_MODE]  = detect_mode_q;
                end
                kpi_pkg::OFS_PIN_ENABLE:  prdata_d = ext_word(pin_enable_mask_q);
                kpi_pkg::OFS_POLARITY:    prdata_d = ext_word(polarity_select_q);
                kpi_pkg::OFS_PULL_ENABLE: prdata_d = ext_word(pull_enable_q);
                kpi_pkg::OFS_IRQ_STATUS:  prdata_d = {30'h0, irq_status_q};
                kpi_pkg::OFS_IRQ_MASK:    prdata_d = {30'h0, irq_mask_q};
                default:                  prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Flag, arming and event status next values
    // ==========================================================
    always_comb
    begin
        prev_d = pin_sync;
        // Re-arm once every enabled pin is deasserted
        if (!any_level)
            armed_d = 1'b1;
        else if (any_edge)
            armed_d = 1'b0;
        else
            armed_d = armed_q;

        key_event_flag_d = key_event_flag_q;
        if (ack_wr && !(detect_mode_q && any_level))
            key_event_flag_d = 1'b0;
        if (detect)
            key_event_flag_d = 1'b1;

        flag_rise    = key_event_flag_d && !key_event_flag_q;
        irq_status_d = irq_status_q;
        if (wr_en && pstrb_in[0] && paddr_in == kpi_pkg::OFS_IRQ_STATUS)
            irq_status_d = irq_status_q & ~pwdata_in[1:0];
        if (any_edge)
            irq_status_d[kpi_pkg::IRQ_EVENT] = 1'b1;
        if (flag_rise)
            irq_status_d[kpi_pkg::IRQ_SET] = 1'b1;
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pin_enable_mask_q <= kpi_pkg::RST_PIN_ENABLE[PINS-1:0];
            polarity_select_q <= kpi_pkg::RST_POLARITY[PINS-1:0];
            pull_enable_q     <= kpi_pkg::RST_PULL[PINS-1:0];
            detect_mode_q     <= 1'b0;
            key_irq_enable_q  <= 1'b0;
            key_event_flag_q  <= 1'b0;
            armed_q           <= 1'b0;
            prev_q            <= '0;
            irq_status_q      <= 2'h0;
            irq_mask_q        <= kpi_pkg::RST_IRQ_MASK;
            prdata_q          <= 32'h0000_0000;
        end
        else
        begin
            pin_enable_mask_q <= pin_enable_mask_d;
            polarity_select_q <= polarity_select_d;
            pull_enable_q     <= pull_enable_d;
            detect_mode_q     <= detect_mode_d;
            key_irq_enable_q  <= key_irq_enable_d;
            key_event_flag_q  <= key_event_flag_d;
            armed_q           <= armed_d;
            prev_q            <= prev_d;
            irq_status_q      <= irq_status_d;
            irq_mask_q        <= irq_mask_d;
            prdata_q          <= prdata_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign pull_up_out   = pull_enable_q & ~polarity_select_q;
    assign pull_down_out = pull_enable_q & polarity_select_q;
    assign key_irq_out   = key_event_flag_q && key_irq_enable_q;
    assign irq_out       = |(irq_status_q & irq_mask_q);
    assign pready_out    = 1'b1;                                                 // Zero wait states
    assign pslverr_out   = psel_in && penable_in && !addr_ok;
    assign prdata_out    = prdata_q;

endmodule // kpi_keyboard_interrupt_unit

// *** test/kpi_unit_asserts.sv ***
/* Checker for the keyboard pin interrupt unit.
   Sees only the unit's top ports; bound at the foot of this file. */
`timescale 1ns/100ps

module kpi_unit_asserts #(
    parameter int PINS = 8
) (
    // Clock, reset and APB
    input  wire logic            clk_in,
    input  wire logic            rst_in,
    input  wire logic            psel_in,
    input  wire logic            penable_in,
    input  wire logic            pwrite_in,
    input  wire logic [7:0]      paddr_in,
    input  wire logic [31:0]     pwdata_in,
    input  wire logic [3:0]      pstrb_in,
    input  wire logic [31:0]     prdata_out,
    input  wire logic            pready_out,
    input  wire logic            pslverr_out,
    // Pulls and interrupts
    input  wire logic [PINS-1:0] pull_up_out,
    input  wire logic [PINS-1:0] pull_down_out,
    input  wire logic            key_irq_out,
    input  wire logic            irq_out
);
    // ==========================================================
    // Access decode
    // ==========================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic acc;
    logic wr_st;
    // Access phase and status writes
    assign acc   = psel_in & penable_in;
    assign wr_st = acc & pwrite_in & pstrb_in[0] & (paddr_in == kpi_pkg::OFS_STATUS_CONTROL);

    // ==========================================================
    // Properties
    // ==========================================================
    chk_ready_always: assert property (pready_out) else $error("pready low");
    chk_err_unmapped: assert property (acc |-> pslverr_out == ((paddr_in[1:0] != 2'h0)
        || (paddr_in > kpi_pkg::OFS_IRQ_MASK))) else $error("pslverr wrong");
    chk_err_zero: assert property (acc && !pwrite_in && pslverr_out |-> prdata_out == 32'h0)
        else $error("refused read not zero");
    chk_status_zero_bits: assert property (acc && !pwrite_in && paddr_in == kpi_pkg::OFS_STATUS_CONTROL
        |-> (prdata_out & 32'hfffffff4) == 32'h0) else $error("status zero bits set");
    chk_pull_disjoint: assert property ((pull_up_out & pull_down_out) == '0)
        else $error("pullup and pulldown both on");
    chk_pull_write: assert property (acc && pwrite_in && pstrb_in[0]
        && paddr_in == kpi_pkg::OFS_PULL_ENABLE |=> (pull_up_out | pull_down_out) == $past(pwdata_in[PINS-1:0]))
        else $error("pull enables not applied");
    chk_key_irq_clear: assert property ($fell(key_irq_out) |-> $past(wr_st))
        else $error("key request fell without status write");
    chk_irq_clear: assert property ($fell(irq_out) |-> $past(acc && pwrite_in
        && (paddr_in == kpi_pkg::OFS_IRQ_STATUS || paddr_in == kpi_pkg::OFS_IRQ_MASK)))
        else $error("interrupt fell without status or mask write");
    // Main scenarios
    cov_key_rise: cover property ($rose(key_irq_out));
    cov_key_fall: cover property ($fell(key_irq_out));
    cov_irq_rise: cover property ($rose(irq_out));
endmodule // kpi_unit_asserts

bind kpi_keyboard_interrupt_unit kpi_unit_asserts #(.PINS(PINS)) u_chk (.clk_in(clk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .pull_up_out(pull_up_out), .pull_down_out(pull_down_out),
    .key_irq_out(key_irq_out), .irq_out(irq_out));

// *** test/kpi_key_model.sv ***
/* Model of the keyboard switches on the unit's pins.
   Assumes the bench presses keys and the unit drives the pull controls. */
`timescale 1ns/100ps

module kpi_key_model #(
    parameter int PINS = 8
) (
    // Clock
    input  wire logic            clk_in,
    // Switch commands
    input  wire logic [PINS-1:0] press_in,
    input  wire logic [PINS-1:0] level_in,
    // Pull control from the unit
    input  wire logic [PINS-1:0] pull_up_in,
    input  wire logic [PINS-1:0] pull_down_in,
    // Pins
    output logic      [PINS-1:0] key_pin_out
);
    logic [PINS-1:0] float_q = '0;
    // A floating pin changes every cycle so no level is taken for granted
    always_ff @(posedge clk_in)
    begin
        float_q <= ~float_q;
    end
    // A pressed switch drives its level, a released one leaves the pull
    always_comb
    begin
        for (int i = 0; i < PINS; i++)
        begin
            key_pin_out[i] = press_in[i] ? level_in[i] : pull_up_in[i] ? 1'b1
                : pull_down_in[i] ? 1'b0 : float_q[i];
        end
    end
endmodule // kpi_key_model

// *** test/tb_keyboard_pin_interrupt.sv ***
/* Bench for the keyboard pin interrupt unit: register rows, then edge,
   level, interrupt and reset cases. Assumes a 200 MHz clock. */
`timescale 1ns/100ps
`define CHECK(g, e) check_val(32'(g), 32'(e))

module tb_keyboard_pin_interrupt;
    // ==========================================================
    // Signals
    // ==========================================================
    localparam logic [7:0] ST = kpi_pkg::OFS_STATUS_CONTROL;
    localparam logic [7:0] PE = kpi_pkg::OFS_PIN_ENABLE;
    localparam logic [7:0] PO = kpi_pkg::OFS_POLARITY;
    localparam logic [7:0] PU = kpi_pkg::OFS_PULL_ENABLE;
    localparam logic [7:0] IS = kpi_pkg::OFS_IRQ_STATUS;
    localparam logic [7:0] IM = kpi_pkg::OFS_IRQ_MASK;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} kpi_row_t;
    kpi_row_t    rows [10] = '{'{PO, 32'ha5, 32'ha5, 1'b0}, '{PU, 32'hff, 32'hff, 1'b0},
        '{ST, 32'hff, 32'h03, 1'b0}, '{ST, 32'h00, 32'h00, 1'b0}, '{PE, 32'h1ff, 32'hff, 1'b0},
        '{PE, 32'h00, 32'h00, 1'b0}, '{IM, 32'hff, 32'h03, 1'b0}, '{IM, 32'h00, 32'h00, 1'b0},
        '{8'h18, 32'hff, 32'h00, 1'b1}, '{8'h02, 32'hff, 32'h00, 1'b1}};
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic        pready_out, pslverr_out, key_irq_out, irq_out;
    logic [7:0]  key_pin, pull_up_out, pull_down_out;
    logic [7:0]  press = 8'h00;
    logic [7:0]  level = 8'h00;
    logic [31:0] rq;
    logic        re;
    int          n_fail = 0;
    int          n_compared = 0;
    int          cycles = 0;

    // ==========================================================
    // Unit, switches, clock and timeout
    // ==========================================================
    kpi_keyboard_interrupt_unit #(.PINS(8)) DUT (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .pstrb_in(4'hf), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .key_pin_in(key_pin), .pull_up_out(pull_up_out), .pull_down_out(pull_down_out),
        .key_irq_out(key_irq_out), .irq_out(irq_out));
    kpi_key_model #(.PINS(8)) u_keys (.clk_in(clk_in), .press_in(press), .level_in(level),
        .pull_up_in(pull_up_out), .pull_down_in(pull_down_out), .key_pin_out(key_pin));
    // Clock
    always #2.5 clk_in = ~clk_in;
    // Hang guard
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_fail++;
            finish_test();
        end
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rq = prdata_out;
        re = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic key(input logic [7:0] p, input logic [7:0] l);
        @(posedge clk_in);
        press <= p;
        level <= l;
    endtask
    // Bounded wait for the key request
    task automatic wait_irq(input logic e);
        @(negedge clk_in);
        for (int i = 0; i < 12 && key_irq_out !== e; i++) @(negedge clk_in);
        `CHECK(key_irq_out, e);
    endtask
    task automatic settle(input logic e);
        repeat (10) @(negedge clk_in);
        `CHECK(key_irq_out, e);
    endtask
    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask
    task automatic finish_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========================================================
    // Sequence
    // ==========================================================
    initial
    begin
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            `CHECK(rq, rows[i].q);
            `CHECK(re, rows[i].e);
        end
        @(negedge clk_in);
        `CHECK({pull_up_out, pull_down_out}, 16'h5aa5);
        tdone("rows");
        wr(PO, 32'h00);
        wr(PE, 32'h01);
        wr(ST, 32'h04);
        wr(ST, 32'h02);
        key(8'h02, 8'h00);
        settle(1'b0);
        key(8'h01, 8'h00);
        wait_irq(1'b1);
        rd(ST);
        `CHECK(rq, 32'h0a);
        wr(ST, 32'h06);
        wait_irq(1'b0);
        settle(1'b0);
        // Pin 1 goes active while pin 0 is still held: no new edge may count
        wr(PE, 32'h03);
        key(8'h03, 8'h00);
        settle(1'b0);
        key(8'h00, 8'h00);
        repeat (6) @(posedge clk_in);
        key(8'h01, 8'h00);
        wait_irq(1'b1);
        key(8'h00, 8'h00);
        wr(ST, 32'h00);
        wait_irq(1'b0);
        rd(ST);
        `CHECK(rq, 32'h08);
        wr(ST, 32'h0e);
        rd(ST);
        `CHECK(rq, 32'h02);
        tdone("falling edge");
        rd(IS);
        `CHECK(rq, 32'h03);
        `CHECK(irq_out, 0);
        wr(IM, 32'h03);
        @(negedge clk_in);
        `CHECK(irq_out, 1);
        wr(IS, 32'h03);
        @(negedge clk_in);
        `CHECK(irq_out, 0);
        tdone("interrupt");
        wr(ST, 32'h00);
        wr(PO, 32'h01);
        @(negedge clk_in);
        `CHECK({pull_up_out, pull_down_out}, 16'hfe01);
        wr(ST, 32'h04);
        wr(ST, 32'h02);
        key(8'h01, 8'h01);
        wait_irq(1'b1);
        key(8'h00, 8'h00);
        wr(ST, 32'h06);
        wait_irq(1'b0);
        tdone("rising edge");
        // Edge consumed and cleared in edge mode, so only the held level can set the flag
        key(8'h01, 8'h01);
        settle(1'b1);
        wr(ST, 32'h06);
        wait_irq(1'b0);
        wr(ST, 32'h03);
        wait_irq(1'b1);
        wr(ST, 32'h07);
        @(negedge clk_in);
        `CHECK(key_irq_out, 1);
        settle(1'b1);
        key(8'h00, 8'h00);
        repeat (6) @(posedge clk_in);
        wr(ST, 32'h07);
        wait_irq(1'b0);
        tdone("level");
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int a = 0; a < 24; a += 4)
        begin
            rd(8'(a));
            `CHECK(rq, 0);
        end
        `CHECK(irq_out, 0);
        tdone("reset");
        finish_test();
    end
endmodule // tb_keyboard_pin_interrupt
